// *** logic/cec_pkg.sv ***
`default_nettype none
package cec_pkg;
	// Field layout of each counter/threshold register
	localparam int CNT_W        = 27;
	localparam int PTR_LSB      = 27;
	localparam int PTR_MSB      = 31;
	localparam int PTR_W        = 5;
	localparam logic [4:0] PTR_MAX = 5'h1A;
	// Control/status addresses
	localparam int ADDR_W       = 12;
	localparam logic [11:0] ADDR_IC   = 12'h7F0;
	localparam logic [11:0] ADDR_ITM  = 12'h7F1;
	localparam logic [11:0] ADDR_DTM  = 12'h7F2;
	// Reset values
	localparam logic [26:0] CNT_RST = 27'h0000000;
	localparam logic [4:0]  PTR_RST = 5'h00;
	localparam int NSRC         = 3;
	// Counter source index
	typedef enum {CEC_SRC_IC, CEC_SRC_ITM, CEC_SRC_DTM} cec_src_type;
endpackage
`default_nettype wire

// *** logic/cec_if.sv ***
`timescale 1ns/1ps
`default_nettype none
// Per-counter write/increment bundle between top and counter slice
interface cec_cnt_if;
	logic        inc;   // One increment this cycle
	logic        wr;    // Firmware write strobe
	logic [31:0] wdata; // Write data
	logic [31:0] value; // Stored register value
	logic        hit;   // Selected counter bit set
	modport ctr (input inc, input wr, input wdata, output value, output hit);
	modport top (output inc, output wr, output wdata, input value, input hit);
endinterface
`default_nettype wire

// *** logic/cec_counter.sv ***
`timescale 1ns/1ps
`default_nettype none
// One counter with its threshold pointer
module cec_counter (
	input  wire logic mclk,
	input  wire logic rst,
	cec_cnt_if.ctr    p
);
	logic [26:0] cnt_r;   // Error count
	logic [26:0] cnt_nxt;
	logic [4:0]  ptr_r;   // Threshold bit pointer
	logic [4:0]  ptr_nxt;
	logic [4:0]  wptr;    // Written pointer field

	// Write beats increment; count wraps freely
	always_comb begin
		wptr    = p.wdata[cec_pkg::PTR_MSB:cec_pkg::PTR_LSB];
		cnt_nxt = cnt_r;
		ptr_nxt = ptr_r;
		if (p.wr) begin
			cnt_nxt = p.wdata[cec_pkg::CNT_W-1:0];
			// Illegal pointers fold to the top legal one
			ptr_nxt = (wptr > cec_pkg::PTR_MAX) ? cec_pkg::PTR_MAX : wptr;
		end else if (p.inc) begin
			cnt_nxt = cnt_r + 27'h0000001;
		end
	end

	// State registers
	always_ff @(posedge mclk) begin
		if (rst) begin
			cnt_r <= cec_pkg::CNT_RST;
			ptr_r <= cec_pkg::PTR_RST;
		end else begin
			cnt_r <= cnt_nxt;
			ptr_r <= ptr_nxt;
		end
	end

	// Level, never latched; clears as soon as the count does
	assign p.hit   = cnt_r[ptr_r];
	assign p.value = {ptr_r, cnt_r};

	// Stored pointer never leaves the legal range
	a_ptr_legal: assert property (@(posedge mclk) disable iff (rst)
		ptr_r <= cec_pkg::PTR_MAX) else $error("pointer out of range");
	// A write lands whole, even against a same-cycle event
	a_write_wins: assert property (@(posedge mclk) disable iff (rst)
		p.wr |=> cnt_r == $past(p.wdata[26:0])) else $error("write lost");
	// One step per event, wrapping freely at the top
	a_inc_one: assert property (@(posedge mclk) disable iff (rst)
		p.inc && !p.wr |=> cnt_r == $past(cnt_r) + 27'h0000001) else $error("bad step");
	// Reads alone never disturb either field
	a_hold_idle: assert property (@(posedge mclk) disable iff (rst)
		!p.inc && !p.wr |=> $stable(cnt_r) && $stable(ptr_r)) else $error("drift");
	// Illegal pointers fold to the top legal value rather than wrap
	a_fold_ptr: assert property (@(posedge mclk) disable iff (rst)
		p.wr && p.wdata[cec_pkg::PTR_MSB:cec_pkg::PTR_LSB] > cec_pkg::PTR_MAX
		|=> ptr_r == cec_pkg::PTR_MAX) else $error("no fold");
	// Legal pointers are kept exactly as written
	a_ptr_keep: assert property (@(posedge mclk) disable iff (rst)
		p.wr && p.wdata[cec_pkg::PTR_MSB:cec_pkg::PTR_LSB] <= cec_pkg::PTR_MAX
		|=> ptr_r == $past(p.wdata[cec_pkg::PTR_MSB:cec_pkg::PTR_LSB]))
		else $error("pointer changed");
	c_wrap: cover property (@(posedge mclk) p.inc && !p.wr && (&cnt_r));
endmodule
`default_nettype wire

// *** logic/cec_top.sv ***
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Cache tag or fetch error bumps cache counter
// - Many cache errors per cycle count once
// - Pointer bits 31:27, counter bits 26:0
// - Pointers 27-31 store as 26
// - Firmware reads harmlessly, writes both fields
// - Interrupt is level of selected bit
// - Clearing counter drops interrupt next cycle
// - Counter wraps, never saturates
// - Instruction memory fetch or DMA errors counted
// - Fetch errors counted even if unexecuted
// - Instruction DMA errors counted in any state
// - Data counter: retired access or DMA only
// - Data write-back only on retirement
// - Data DMA errors counted in any state
// - Write any value, read legal value
// - Registers at 0x7F0, 0x7F1, 0x7F2
// - Single-bit error detection drives counters
module cec_top (
	input  wire logic        mclk,
	input  wire logic        rst,
	input  wire logic [3:0]  ic_err_vec,       // Per tag/way cache error flags
	input  wire logic        ic_fetch_err,     // Cache fetch data error
	input  wire logic        itm_fetch_sbe,    // Instr memory fetch single-bit error
	input  wire logic        itm_dma_sbe,      // Instr memory DMA read single-bit error
	input  wire logic        dtm_ls_sbe,       // Data memory load/store single-bit error
	input  wire logic        dtm_ls_retire,    // That access retires
	input  wire logic        dtm_ls_spec,      // That access is speculative
	input  wire logic        dtm_ls_exc,       // That access takes an exception
	input  wire logic        dtm_dma_sbe,      // Data memory DMA read single-bit error
	input  wire logic        debug_halted_state, // Core in debug halt
	input  wire logic        power_sleep_state,  // Core in sleep
	input  wire logic        csr_rd,           // Register read strobe
	input  wire logic        csr_wr,           // Register write strobe
	input  wire logic [11:0] csr_addr,         // Register address
	input  wire logic [31:0] csr_wdata,        // Register write data
	output logic [31:0]      csr_rdata,        // Registered read data
	output logic             csr_hit,          // Address decoded, registered
	output logic             dtm_wb_en,        // Data memory correction write-back
	output logic             ce_irq            // Correctable-error local interrupt
);
	cec_cnt_if cif [cec_pkg::NSRC] ();
	logic [cec_pkg::NSRC-1:0] inc;       // Increment per source
	logic [cec_pkg::NSRC-1:0] sel;       // Address match per source
	logic [cec_pkg::NSRC-1:0] hit;       // Threshold hit per source
	logic [31:0]              val [cec_pkg::NSRC];
	logic [31:0]              rdata_nxt;
	logic                     dec_nxt;
	logic                     irq_nxt;
	logic                     wb_nxt;
	logic [31:0]              rdata_r;
	logic                     hit_r;
	logic                     irq_r;
	logic                     wb_r;

	// Address decode, shared by read and write paths
	function automatic logic [2:0] dec(input logic [11:0] a);
		dec = {a == cec_pkg::ADDR_DTM, a == cec_pkg::ADDR_ITM, a == cec_pkg::ADDR_IC};
	endfunction

	// Event qualification; power state is deliberately not looked at
	always_comb begin
		inc[0] = (|ic_err_vec) | ic_fetch_err;
		inc[1] = itm_fetch_sbe | itm_dma_sbe;
		inc[2] = (dtm_ls_sbe & dtm_ls_retire & ~dtm_ls_spec & ~dtm_ls_exc)
		         | dtm_dma_sbe;
		wb_nxt = dtm_ls_sbe & dtm_ls_retire & ~dtm_ls_spec & ~dtm_ls_exc;
		sel    = dec(csr_addr);
	end

	// Counter slices, one per source
	genvar g;
	generate
		for (g = 0; g < cec_pkg::NSRC; g++) begin : g_ctr
			assign cif[g].inc   = inc[g];
			assign cif[g].wr    = csr_wr & sel[g];
			assign cif[g].wdata = csr_wdata;
			assign val[g]       = cif[g].value;
			assign hit[g]       = cif[g].hit;
			cec_counter u_ctr (
				.mclk (mclk),
				.rst  (rst),
				.p    (cif[g])
			);
		end
	endgenerate

	// Read mux and interrupt combine; unmapped reads return zero
	always_comb begin
		rdata_nxt = 32'h00000000;
		dec_nxt   = csr_rd & (|sel);
		for (int i = 0; i < cec_pkg::NSRC; i++) begin
			if (csr_rd && sel[i]) begin
				rdata_nxt = val[i];
			end
		end
		irq_nxt = |hit;
	end

	// Output registers
	always_ff @(posedge mclk) begin
		if (rst) begin
			rdata_r <= 32'h00000000;
			hit_r   <= 1'b0;
			irq_r   <= 1'b0;
			wb_r    <= 1'b0;
		end else begin
			rdata_r <= rdata_nxt;
			hit_r   <= dec_nxt;
			irq_r   <= irq_nxt;
			wb_r    <= wb_nxt;
		end
	end

	// Every output leaves straight from its flop
	assign csr_rdata = rdata_r;
	assign csr_hit   = hit_r;
	assign ce_irq    = irq_r;
	assign dtm_wb_en = wb_r;

	// Interrupt flop tracks the OR of the three hits, one edge late
	a_irq_follow: assert property (@(posedge mclk) disable iff (rst)
		##1 ce_irq == $past(|hit)) else $error("irq mismatch");

	// Clearing a count drops the line unless another counter holds it up
	a_clear_irq: assert property (@(posedge mclk) disable iff (rst)
		csr_wr && (|sel) && csr_wdata[26:0] == 27'h0000000
		&& !(|(hit & ~sel)) && !(|(inc & ~sel)) |-> ##2 !ce_irq)
		else $error("irq not cleared");

	// Speculative loads and stores leave the data count alone
	a_no_spec: assert property (@(posedge mclk) disable iff (rst)
		dtm_ls_spec && !dtm_dma_sbe && !(csr_wr && sel[2])
		|=> val[2][26:0] == $past(val[2][26:0])) else $error("speculative counted");

	// Excepting accesses are dropped the same way
	a_no_exc: assert property (@(posedge mclk) disable iff (rst)
		dtm_ls_exc && !dtm_dma_sbe && !(csr_wr && sel[2])
		|=> val[2][26:0] == $past(val[2][26:0])) else $error("excepting counted");

	// An error on an access that never retires is not counted
	a_no_unretired: assert property (@(posedge mclk) disable iff (rst)
		dtm_ls_sbe && !dtm_ls_retire && !dtm_dma_sbe && !(csr_wr && sel[2])
		|=> val[2][26:0] == $past(val[2][26:0])) else $error("unretired counted");

	// A retired, clean load or store bumps the data count by one
	a_ls_step: assert property (@(posedge mclk) disable iff (rst)
		dtm_ls_sbe && dtm_ls_retire && !dtm_ls_spec && !dtm_ls_exc && !(csr_wr && sel[2])
		|=> val[2][26:0] == $past(val[2][26:0]) + 27'h0000001)
		else $error("data step lost");

	// Many tag flags in one cycle still count once
	a_multi_once: assert property (@(posedge mclk) disable iff (rst)
		(|ic_err_vec) && !(csr_wr && sel[0])
		|=> val[0][26:0] == $past(val[0][26:0]) + 27'h0000001)
		else $error("cache step not one");

	// A fetch error alone also steps the cache count
	a_fetch_step: assert property (@(posedge mclk) disable iff (rst)
		ic_fetch_err && !(csr_wr && sel[0])
		|=> val[0][26:0] == $past(val[0][26:0]) + 27'h0000001)
		else $error("cache fetch lost");

	// Fetch errors count whether or not the instruction runs
	a_itm_fetch: assert property (@(posedge mclk) disable iff (rst)
		itm_fetch_sbe && !(csr_wr && sel[1])
		|=> val[1][26:0] == $past(val[1][26:0]) + 27'h0000001)
		else $error("fetch error lost");

	// DMA read errors on the instruction memory count too
	a_itm_dma: assert property (@(posedge mclk) disable iff (rst)
		itm_dma_sbe && !(csr_wr && sel[1])
		|=> val[1][26:0] == $past(val[1][26:0]) + 27'h0000001)
		else $error("dma error lost");

	// Sleep does not gate instruction memory DMA counting
	a_dma_sleep: assert property (@(posedge mclk) disable iff (rst)
		itm_dma_sbe && power_sleep_state && !(csr_wr && sel[1])
		|=> val[1][26:0] == $past(val[1][26:0]) + 27'h0000001)
		else $error("sleep dma lost");

	// Debug halt does not gate data memory DMA counting
	a_dma_halt: assert property (@(posedge mclk) disable iff (rst)
		dtm_dma_sbe && debug_halted_state && !(csr_wr && sel[2])
		|=> val[2][26:0] == $past(val[2][26:0]) + 27'h0000001)
		else $error("halt dma lost");

	// Write-back strobe only follows a retired access
	a_wb_retire: assert property (@(posedge mclk) disable iff (rst)
		dtm_wb_en |-> $past(dtm_ls_retire)) else $error("write-back unretired");

	// A qualified access always gets its write-back
	a_wb_qual: assert property (@(posedge mclk) disable iff (rst)
		dtm_ls_sbe && dtm_ls_retire && !dtm_ls_spec && !dtm_ls_exc |=> dtm_wb_en) else $error("write-back lost");

	// Read data is the register as it stood at the taking edge
	a_read_ic: assert property (@(posedge mclk) disable iff (rst)
		csr_rd && sel[0] |=> csr_rdata == $past(val[0])) else $error("bad cache read");
	a_read_val: assert property (@(posedge mclk) disable iff (rst)
		csr_rd && sel[1] |=> csr_rdata == $past(val[1])) else $error("bad read");
	a_read_dtm: assert property (@(posedge mclk) disable iff (rst)
		csr_rd && sel[2] |=> csr_rdata == $past(val[2])) else $error("bad data read");

	// Unmapped reads give zero and no hit
	a_rd_unmapped: assert property (@(posedge mclk) disable iff (rst)
		csr_rd && !(|sel) |=> csr_rdata == 32'h00000000 && !csr_hit) else $error("unmapped read");

	// Mapped reads always raise the hit flag
	a_rd_hit: assert property (@(posedge mclk) disable iff (rst)
		csr_rd && (|sel) |=> csr_hit) else $error("hit missing");

	// Writes off the three addresses touch nothing
	a_wr_unmapped: assert property (@(posedge mclk) disable iff (rst)
		csr_wr && !(|sel) && !(|inc)
		|=> val[0] == $past(val[0]) && val[1] == $past(val[1]) && val[2] == $past(val[2]))
		else $error("unmapped write landed");

	// Main scenarios worth seeing at least once
	c_irq: cover property (@(posedge mclk) $rose(ce_irq));
	c_wr_inc: cover property (@(posedge mclk) csr_wr && (|(sel & inc)));
	c_dma_sleep: cover property (@(posedge mclk) dtm_dma_sbe && power_sleep_state);
	c_ls_count: cover property (@(posedge mclk) dtm_ls_sbe && dtm_ls_retire && !dtm_ls_spec);
endmodule
`default_nettype wire

// *** verif/cec_partner.sv ***
`timescale 1ns/1ps
`default_nettype none
// Error detectors and core state levels that feed the counters
module cec_partner (
	input  wire logic  mclk,
	output logic [13:0] ev
);
	// Flags idle low; detectors report nothing between bursts
	initial ev = 14'h0000;
	// One-cycle burst driven just after an edge, then idle again
	task automatic fire(input logic [13:0] v);
		@(posedge mclk);
		#1 ev = v;
		@(posedge mclk);
		#1 ev = 14'h0000;
	endtask
endmodule
`default_nettype wire

// *** verif/tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic        mclk = 1'b0;
	logic        rst = 1'b1;
	logic        csr_rd = 1'b0;
	logic        csr_wr = 1'b0;
	logic [11:0] csr_addr = 12'h000;
	logic [31:0] csr_wdata = 32'h00000000;
	logic [31:0] csr_rdata;
	logic        csr_hit;
	logic        dtm_wb_en;
	logic        ce_irq;
	logic [13:0] ev;
	int          err_total = 0;
	int          checked = 0;
	int          cyc = 0;
	logic [31:0] exp_c [3];
	// Per entry: expected bumps {cache, instr, data, writeback}, then event code
	localparam logic [17:0] TBL [10] = '{18'h23E00, 18'h20800, 18'h20200, 18'h10100,
		18'h10083, 18'h0C060, 18'h00070, 18'h00068, 18'h00040, 18'h08007};
	always #2.5 mclk = ~mclk;
	cec_partner u_cec_partner (.mclk(mclk), .ev(ev));
	cec_top u_cec_top (.mclk(mclk), .rst(rst), .ic_err_vec(ev[13:10]), .ic_fetch_err(ev[9]),
		.itm_fetch_sbe(ev[8]), .itm_dma_sbe(ev[7]), .dtm_ls_sbe(ev[6]), .dtm_ls_retire(ev[5]),
		.dtm_ls_spec(ev[4]), .dtm_ls_exc(ev[3]), .dtm_dma_sbe(ev[2]),
		.debug_halted_state(ev[1]), .power_sleep_state(ev[0]), .csr_rd(csr_rd),
		.csr_wr(csr_wr), .csr_addr(csr_addr), .csr_wdata(csr_wdata), .csr_rdata(csr_rdata),
		.csr_hit(csr_hit), .dtm_wb_en(dtm_wb_en), .ce_irq(ce_irq));
	// Compare and count
	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			err_total++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask
	// Write strobe held for the one edge that takes it
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		@(posedge mclk);
		#1 {csr_wr, csr_addr, csr_wdata} = {1'b1, a, d};
		@(posedge mclk);
		#1 csr_wr = 1'b0;
	endtask
	// Read data stands just after the taking edge, checked 1 ns later
	task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic h);
		@(posedge mclk);
		#1 {csr_rd, csr_addr} = {1'b1, a};
		@(posedge mclk);
		#1 csr_rd = 1'b0;
		chk("csr_rdata", csr_rdata, e);
		chk("csr_hit", {31'h0, csr_hit}, {31'h0, h});
	endtask
	// Interrupt lags its cause by two edges
	task automatic irq(input logic e);
		repeat (2) @(posedge mclk);
		#1 chk("ce_irq", {31'h0, ce_irq}, {31'h0, e});
	endtask
	task automatic wrap_up();
		$display("checked %0d err_total %0d", checked, err_total);
		if (err_total == 0 && checked > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	// Hang guard, far above the roughly 135 cycles needed
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 3000) begin
			err_total++;
			wrap_up();
		end
	end
	initial begin
		repeat (3) @(posedge mclk);
		#1 rst = 1'b0;
		for (int i = 0; i < 3; i++) begin
			exp_c[i] = 32'h0;
			rd(cec_pkg::ADDR_IC + 12'(i), 32'h0, 1'b1);
		end
		rd(12'h7F3, 32'h0, 1'b0);
		wr(12'h7F3, 32'hFFFFFFFF);
		rd(cec_pkg::ADDR_IC, 32'h0, 1'b1);
		wr(cec_pkg::ADDR_IC, 32'hF8000001);
		rd(cec_pkg::ADDR_IC, 32'hD0000001, 1'b1);
		rd(cec_pkg::ADDR_IC, 32'hD0000001, 1'b1);
		exp_c[0] = 32'hD0000001;
		// Every event kind and each data qualifier alone, all three counters read back
		foreach (TBL[i]) begin
			u_cec_partner.fire(TBL[i][13:0]);
			chk("dtm_wb_en", {31'h0, dtm_wb_en}, {31'h0, TBL[i][14]});
			for (int k = 0; k < 3; k++) begin
				exp_c[k] += {31'h0, TBL[i][17 - k]};
				rd(cec_pkg::ADDR_IC + 12'(k), exp_c[k], 1'b1);
			end
		end
		wr(cec_pkg::ADDR_ITM, 32'h08000001);
		irq(1'b0);
		u_cec_partner.fire(14'h0100);
		irq(1'b1);
		u_cec_partner.fire(14'h0100);
		irq(1'b1);
		u_cec_partner.fire(14'h0100);
		irq(1'b0);
		wr(cec_pkg::ADDR_DTM, 32'h00000001);
		irq(1'b1);
		wr(cec_pkg::ADDR_DTM, 32'h00000000);
		irq(1'b0);
		wr(cec_pkg::ADDR_DTM, 32'h07FFFFFF);
		u_cec_partner.fire(14'h0004);
		rd(cec_pkg::ADDR_DTM, 32'h00000000, 1'b1);
		// Write and increment meet on one edge
		fork
			wr(cec_pkg::ADDR_IC, 32'h00000005);
			u_cec_partner.fire(14'h0200);
		join
		rd(cec_pkg::ADDR_IC, 32'h00000005, 1'b1);
		wrap_up();
	end
endmodule
`default_nettype wire
